// [common/ioev_defines.svh]
`ifndef IOEV_DEFINES_SVH
`define IOEV_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define IOEV_OFS_SENSE_HIGH_B 7'h14
`define IOEV_OFS_SENSE_LOW_B  7'h15
`define IOEV_OFS_SENSE_HIGH_A 7'h16
`define IOEV_OFS_SENSE_LOW_A  7'h17
`define IOEV_OFS_IRQ_B        7'h18
`define IOEV_OFS_IRQ_A        7'h19
`define IOEV_OFS_EVT_B        7'h1A
`define IOEV_OFS_EVT_A        7'h1B
`define IOEV_OFS_PAIR_UPPER   7'h1C

// ----------------------------------------
// reset values and field codes
// ----------------------------------------
`define IOEV_RESET_BYTE 8'h00
`define IOEV_EDGE_NONE  2'h0
`define IOEV_EDGE_RISE  2'h1
`define IOEV_EDGE_FALL  2'h2
`define IOEV_EDGE_BOTH  2'h3
`define IOEV_LS_OFF     2'h0
`define IOEV_LS_A2B     2'h1
`define IOEV_LS_B2A     2'h2
`define IOEV_LS_RSVD    2'h3

// ----------------------------------------
// serial frame counts
// ----------------------------------------
`define IOEV_SPI_LAST_ADDR_BIT 5'h07
`define IOEV_SPI_LAST_BIT      5'h0F

`endif

// [common/ioev_pkg.sv]
package ioev_pkg;

   typedef struct packed
   {
      logic       wr;
      logic [6:0] addr;
      logic [7:0] wdata;
   } ioev_req_t;

   typedef enum logic [1:0] {SPI_IDLE, SPI_ADDR, SPI_DATA, SPI_DONE} ioev_spi_state_t;

endpackage

// [core/ioev_spi_slave.sv]
`include "ioev_defines.svh"

module ioev_spi_slave
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              spi_sck,
   input  wire logic              spi_mosi,
   input  wire logic              spi_cs_n,
   input  wire logic [7:0]        rdata,
   output ioev_pkg::ioev_req_t    req,
   output logic                   spi_miso_o,
   output logic                   spi_miso_oe
);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic sck_m_r, sck_s_r, sck_d_r, mosi_m_r, mosi_s_r, cs_n_m_r, cs_n_s_r;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sck_m_r  <= 1'b0;
         sck_s_r  <= 1'b0;
         sck_d_r  <= 1'b0;
         mosi_m_r <= 1'b0;
         mosi_s_r <= 1'b0;
         cs_n_m_r <= 1'b1;
         cs_n_s_r <= 1'b1;
      end
      else
      begin
         sck_m_r  <= spi_sck;
         sck_s_r  <= sck_m_r;
         sck_d_r  <= sck_s_r;
         mosi_m_r <= spi_mosi;
         mosi_s_r <= mosi_m_r;
         cs_n_m_r <= spi_cs_n;
         cs_n_s_r <= cs_n_m_r;
      end
   end

   logic sck_rise, sck_fall;
   assign sck_rise = sck_s_r & ~sck_d_r;
   assign sck_fall = ~sck_s_r & sck_d_r;

   // ----------------------------------------
   // frame state machine
   // ----------------------------------------
   ioev_pkg::ioev_spi_state_t state_r, state_nxt;
   logic [4:0]          cnt_r, cnt_nxt;
   logic [7:0]          sh_r, sh_nxt, tx_r, tx_nxt;
   logic                rd_r, rd_nxt, loaded_r, loaded_nxt, miso_r, miso_nxt, oe_r, oe_nxt;
   ioev_pkg::ioev_req_t req_r, req_nxt;

   always_comb
   begin
      state_nxt  = state_r;
      cnt_nxt    = cnt_r;
      sh_nxt     = sh_r;
      tx_nxt     = tx_r;
      rd_nxt     = rd_r;
      loaded_nxt = loaded_r;
      miso_nxt   = miso_r;
      oe_nxt     = oe_r;
      req_nxt    = req_r;
      req_nxt.wr = 1'b0;
      if (cs_n_s_r)
      begin
         state_nxt = ioev_pkg::SPI_IDLE;
         oe_nxt    = 1'b0;
      end
      else
      begin
         case (state_r)
            ioev_pkg::SPI_IDLE:
            begin
               state_nxt  = ioev_pkg::SPI_ADDR;
               cnt_nxt    = 5'h00;
               loaded_nxt = 1'b0;
               miso_nxt   = 1'b0;
               oe_nxt     = 1'b1;
            end
            ioev_pkg::SPI_ADDR, ioev_pkg::SPI_DATA:
            begin
               if (sck_rise)
               begin
                  sh_nxt  = {sh_r[6:0], mosi_s_r};
                  cnt_nxt = cnt_r + 5'h01;
                  if (cnt_r == `IOEV_SPI_LAST_ADDR_BIT)
                  begin
                     // first header bit is read (1) or write (0)
                     state_nxt    = ioev_pkg::SPI_DATA;
                     rd_nxt       = sh_r[6];
                     req_nxt.addr = {sh_r[5:0], mosi_s_r};
                  end
                  else if (cnt_r == `IOEV_SPI_LAST_BIT)
                  begin
                     state_nxt     = ioev_pkg::SPI_DONE;
                     req_nxt.wr    = ~rd_r;
                     req_nxt.wdata = {sh_r[6:0], mosi_s_r};
                  end
               end
               else if (sck_fall && state_r == ioev_pkg::SPI_DATA)
               begin
                  if (!loaded_r)
                  begin
                     miso_nxt   = rdata[7];
                     tx_nxt     = {rdata[6:0], 1'b0};
                     loaded_nxt = 1'b1;
                  end
                  else
                  begin
                     miso_nxt = tx_r[7];
                     tx_nxt   = {tx_r[6:0], 1'b0};
                  end
               end
            end
            ioev_pkg::SPI_DONE:
            begin
               state_nxt = ioev_pkg::SPI_DONE;
            end
            default:
            begin
               state_nxt = ioev_pkg::SPI_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_r  <= ioev_pkg::SPI_IDLE;
         cnt_r    <= 5'h00;
         sh_r     <= 8'h00;
         tx_r     <= 8'h00;
         rd_r     <= 1'b0;
         loaded_r <= 1'b0;
         miso_r   <= 1'b0;
         oe_r     <= 1'b0;
         req_r    <= '0;
      end
      else
      begin
         state_r  <= state_nxt;
         cnt_r    <= cnt_nxt;
         sh_r     <= sh_nxt;
         tx_r     <= tx_nxt;
         rd_r     <= rd_nxt;
         loaded_r <= loaded_nxt;
         miso_r   <= miso_nxt;
         oe_r     <= oe_nxt;
         req_r    <= req_nxt;
      end
   end

   assign req         = req_r;
   assign spi_miso_o  = miso_r;
   assign spi_miso_oe = oe_r;

endmodule

// [core/ioev_regs.sv]
// Summary of operation
// - an IO enabled in the mask sets its interrupt source bit when its selected edge occurs.
// - writing one to an interrupt source bit clears it and the matching event bit; zero does nothing.
// - the interrupt line returns high once every interrupt source bit of both banks is clear.
// - every IO has an event status bit that is set when its selected edge is seen.
// - writing one to an event status bit clears it and the matching interrupt source bit.
// - rewriting an IO's edge selection to a new value clears that IO's pending event bit.
// - each 2-bit pair field selects off, bank A to bank B, bank B to bank A, or reserved.
// - upper pair register bits 7:6 serve IO7/IO15 down to bits 1:0 for IO4/IO12.
// - in the low bank A selection register bits 3:2 serve data bit 1 and bits 1:0 data bit 0.
// - an edge field codes 00 none, 01 rising, 10 falling and 11 both.
`include "ioev_defines.svh"

module ioev_regs
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        spi_sck,
   input  wire logic        spi_mosi,
   input  wire logic        spi_cs_n,
   output logic             spi_miso_o,
   output logic             spi_miso_oe,
   input  wire logic [15:0] pin_value,
   input  wire logic [15:0] irq_enable_mask,
   output logic             irq_out_n_o,
   output logic             irq_out_n_oe,
   output logic [3:0]       ls_a_to_b,
   output logic [3:0]       ls_b_to_a
);

   ioev_pkg::ioev_req_t req;
   logic [7:0]          rdata;

   ioev_spi_slave u_spi
   (
      .clk         (clk),
      .rst         (rst),
      .spi_sck     (spi_sck),
      .spi_mosi    (spi_mosi),
      .spi_cs_n    (spi_cs_n),
      .rdata       (rdata),
      .req         (req),
      .spi_miso_o  (spi_miso_o),
      .spi_miso_oe (spi_miso_oe)
   );

   // ----------------------------------------
   // pin synchronisers and edges
   // ----------------------------------------
   logic [15:0] pin_m_r, pin_s_r, pin_d_r;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pin_m_r <= 16'h0000;
         pin_s_r <= 16'h0000;
         pin_d_r <= 16'h0000;
      end
      else
      begin
         pin_m_r <= pin_value;
         pin_s_r <= pin_m_r;
         pin_d_r <= pin_s_r;
      end
   end

   logic [15:0] rise, fall;
   assign rise = pin_s_r & ~pin_d_r;
   assign fall = ~pin_s_r & pin_d_r;

   // ----------------------------------------
   // state registers
   // ----------------------------------------
   logic [31:0] sel_r, sel_nxt;
   logic [15:0] evt_r, evt_nxt, irq_r, irq_nxt, hit;
   logic [7:0]  pair_r, pair_nxt;
   logic [3:0]  a2b_r, a2b_nxt, b2a_r, b2a_nxt;
   logic        irq_oe_r, irq_oe_nxt;

   genvar i;
   generate
      for (i = 0; i < 16; i = i + 1)
      begin : g_io
         logic [1:0] sel_f, new_f;
         logic       sel_wr, w1c_irq, w1c_evt, changed;
         // two bits per IO, IO0 at bits 1:0 of the low bank A selection register
         assign sel_f   = sel_r[2*i+1:2*i];
         assign new_f   = req.wdata[2*(i%4)+1:2*(i%4)];
         assign sel_wr  = req.wr && req.addr == (`IOEV_OFS_SENSE_LOW_A - 7'(i/4));
         assign w1c_irq = req.wr && req.wdata[i%8] &&
                          req.addr == ((i >= 8) ? `IOEV_OFS_IRQ_B : `IOEV_OFS_IRQ_A);
         assign w1c_evt = req.wr && req.wdata[i%8] &&
                          req.addr == ((i >= 8) ? `IOEV_OFS_EVT_B : `IOEV_OFS_EVT_A);
         // only a change of the field counts
         assign changed = sel_wr && new_f != sel_f;
         assign hit[i]  = (sel_f == `IOEV_EDGE_RISE && rise[i]) ||
                          (sel_f == `IOEV_EDGE_FALL && fall[i]) ||
                          (sel_f == `IOEV_EDGE_BOTH && (rise[i] || fall[i]));
         // event bit, a new edge wins over a clear
         assign evt_nxt[i] = hit[i] || (evt_r[i] && !(w1c_evt || w1c_irq || changed));
         // source bit only for enabled IOs
         assign irq_nxt[i] = (hit[i] && irq_enable_mask[i]) || (irq_r[i] && !(w1c_irq || w1c_evt));
         assign sel_nxt[2*i+1:2*i] = sel_wr ? new_f : sel_f;
      end
      for (i = 0; i < 4; i = i + 1)
      begin : g_pair
         // pair i is IO(4+i) with IO(12+i); reserved code drives neither way
         assign a2b_nxt[i] = pair_r[2*i+1:2*i] == `IOEV_LS_A2B;
         assign b2a_nxt[i] = pair_r[2*i+1:2*i] == `IOEV_LS_B2A;
      end
   endgenerate

   always_comb
   begin
      pair_nxt = pair_r;
      if (req.wr && req.addr == `IOEV_OFS_PAIR_UPPER)
      begin
         pair_nxt = req.wdata;
      end
      // pull the line low while any source is pending
      irq_oe_nxt = |irq_r;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sel_r    <= 32'h00000000;
         evt_r    <= {2{`IOEV_RESET_BYTE}};
         irq_r    <= {2{`IOEV_RESET_BYTE}};
         pair_r   <= `IOEV_RESET_BYTE;
         a2b_r    <= 4'h0;
         b2a_r    <= 4'h0;
         irq_oe_r <= 1'b0;
      end
      else
      begin
         sel_r    <= sel_nxt;
         evt_r    <= evt_nxt;
         irq_r    <= irq_nxt;
         pair_r   <= pair_nxt;
         a2b_r    <= a2b_nxt;
         b2a_r    <= b2a_nxt;
         irq_oe_r <= irq_oe_nxt;
      end
   end

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   always_comb
   begin
      case (req.addr)
         `IOEV_OFS_SENSE_HIGH_B: rdata = sel_r[31:24];
         `IOEV_OFS_SENSE_LOW_B:  rdata = sel_r[23:16];
         `IOEV_OFS_SENSE_HIGH_A: rdata = sel_r[15:8];
         `IOEV_OFS_SENSE_LOW_A:  rdata = sel_r[7:0];
         `IOEV_OFS_IRQ_B:        rdata = irq_r[15:8];
         `IOEV_OFS_IRQ_A:        rdata = irq_r[7:0];
         `IOEV_OFS_EVT_B:        rdata = evt_r[15:8];
         `IOEV_OFS_EVT_A:        rdata = evt_r[7:0];
         `IOEV_OFS_PAIR_UPPER:   rdata = pair_r;
         default:                rdata = 8'h00;
      endcase
   end

   assign irq_out_n_o  = 1'b0;
   assign irq_out_n_oe = irq_oe_r;
   assign ls_a_to_b    = a2b_r;
   assign ls_b_to_a    = b2a_r;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_irq_set_mask: assert property (
      |(hit & irq_enable_mask) |=> ((irq_r & $past(hit & irq_enable_mask)) == $past(hit & irq_enable_mask)))
      else $error("enabled edge did not set source bit");
   a_irq_masked_off: assert property (
      (irq_r == 16'h0000 && (hit & irq_enable_mask) == 16'h0000) |=> irq_r == 16'h0000)
      else $error("source bit set without enabled edge");
   a_irq_w1c_both: assert property (
      (req.wr && req.addr == `IOEV_OFS_IRQ_A && req.wdata[0] && !hit[0]) |=> (!irq_r[0] && !evt_r[0]))
      else $error("source write one did not clear both bits");
   a_irq_w0_keep: assert property (
      (req.wr && req.addr == `IOEV_OFS_IRQ_A && !req.wdata[0] && irq_r[0]) |=> irq_r[0])
      else $error("write zero cleared source bit");
   a_line_release: assert property (
      (irq_r == 16'h0000) [*2] |=> !irq_out_n_oe)
      else $error("interrupt line held with no source");
   a_evt_set_edge: assert property (
      hit[12] |=> evt_r[12])
      else $error("edge did not set event bit");
   a_evt_w1c_both: assert property (
      (req.wr && req.addr == `IOEV_OFS_EVT_B && req.wdata[4] && !hit[12]) |=> (!evt_r[12] && !irq_r[12]))
      else $error("event write one did not clear both bits");
   a_sense_chg_clr: assert property (
      (req.wr && req.addr == `IOEV_OFS_SENSE_LOW_A && req.wdata[3:2] != sel_r[3:2] && !hit[1]) |=> !evt_r[1])
      else $error("edge selection change kept event bit");
   a_pair_decode: assert property (
      (pair_r[7:6] == `IOEV_LS_RSVD) |=> (!ls_a_to_b[3] && !ls_b_to_a[3]))
      else $error("reserved pair code drives a direction");
   a_pair_map: assert property (
      (req.wr && req.addr == `IOEV_OFS_PAIR_UPPER && req.wdata[1:0] == `IOEV_LS_A2B) |=> ##1 (ls_a_to_b[0] && !ls_b_to_a[0]))
      else $error("pair field maps to wrong outputs");
   a_sense_field: assert property (
      (req.wr && req.addr == `IOEV_OFS_SENSE_LOW_A) |=> sel_r[3:0] == $past(req.wdata[3:0]))
      else $error("low bank A selection not stored");
   a_edge_code: assert property (
      (sel_r[3:2] == `IOEV_EDGE_FALL && rise[1] && !evt_r[1] && !req.wr) |=> !evt_r[1])
      else $error("falling selection reacted to rising edge");
   a_line_drive: assert property (
      (irq_r != 16'h0000) |=> (irq_out_n_oe && !irq_out_n_o))
      else $error("interrupt line not driven low");

   c_irq_raised: cover property (|irq_r ##1 irq_out_n_oe);
   c_irq_cleared: cover property (irq_out_n_oe ##[1:50] !irq_out_n_oe);
   c_pair_b2a: cover property (|ls_b_to_a);

endmodule

// [verif/ioev_host_model.sv]
module ioev_host_model
(
   input  wire logic clk,
   output logic      spi_sck,
   output logic      spi_mosi,
   output logic      spi_cs_n,
   input  wire logic spi_miso_o,
   input  wire logic spi_miso_oe
);
   timeunit 1ns;
   timeprecision 1ps;

   // a released miso shows the inverse so a stale bit never passes
   wire logic miso_w = spi_miso_oe ? spi_miso_o : ~spi_miso_o;

   initial
   begin
      spi_sck  = 1'b0;
      spi_mosi = 1'b0;
      spi_cs_n = 1'b1;
   end

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   // one frame: header {rd, addr} then one data byte, mode 0
   task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wdata, output logic [7:0] rdata);
      logic [15:0] frame;
      frame = {rd, addr, wdata};
      rdata = 8'h00;
      @(posedge clk);
      spi_cs_n <= 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         spi_mosi <= frame[i];
         idle(6);
         spi_sck <= 1'b1;
         if (i < 8)
         begin
            rdata[i] = miso_w;
         end
         idle(6);
         spi_sck <= 1'b0;
      end
      idle(6);
      spi_cs_n <= 1'b1;
      idle(6);
   endtask
endmodule

// [verif/ioev_regs_tb_top.sv]
`include "ioev_defines.svh"

module ioev_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk;
   logic        rst;
   logic        spi_sck;
   logic        spi_mosi;
   logic        spi_cs_n;
   logic        spi_miso_o;
   logic        spi_miso_oe;
   logic [15:0] pin_value;
   logic [15:0] irq_enable_mask;
   logic        irq_out_n_o;
   logic        irq_out_n_oe;
   logic [3:0]  ls_a_to_b;
   logic [3:0]  ls_b_to_a;
   logic [7:0]  rd;
   logic [3:0]  exp_a2b;
   logic [3:0]  exp_b2a;
   logic [7:0]  pair_tbl [2];
   int          fail_count;
   int          checks_done;

   // open-drain line with pull-up
   wire logic irq_out_n = irq_out_n_oe ? irq_out_n_o : 1'b1;

   always #25 clk = ~clk;

   ioev_regs u_ioev_regs
   (
      .clk             (clk),
      .rst             (rst),
      .spi_sck         (spi_sck),
      .spi_mosi        (spi_mosi),
      .spi_cs_n        (spi_cs_n),
      .spi_miso_o      (spi_miso_o),
      .spi_miso_oe     (spi_miso_oe),
      .pin_value       (pin_value),
      .irq_enable_mask (irq_enable_mask),
      .irq_out_n_o     (irq_out_n_o),
      .irq_out_n_oe    (irq_out_n_oe),
      .ls_a_to_b       (ls_a_to_b),
      .ls_b_to_a       (ls_b_to_a)
   );

   ioev_host_model u_ioev_host_model
   (
      .clk         (clk),
      .spi_sck     (spi_sck),
      .spi_mosi    (spi_mosi),
      .spi_cs_n    (spi_cs_n),
      .spi_miso_o  (spi_miso_o),
      .spi_miso_oe (spi_miso_oe)
   );

   task automatic report_and_stop;
      if (fail_count == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      u_ioev_host_model.xfer(1'b0, a, d, rd);
   endtask

   task automatic rchk(input string name, input logic [6:0] a, input logic [7:0] exp);
      u_ioev_host_model.xfer(1'b1, a, 8'h00, rd);
      check(name, exp, rd);
   endtask

   task automatic pins(input logic [15:0] v);
      @(posedge clk);
      pin_value <= v;
      repeat (10) @(posedge clk);
   endtask

   // bounded wait for the interrupt line level
   task automatic wait_line(input logic exp);
      int n;
      n = 0;
      while (irq_out_n !== exp && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      check("irq line", {7'h00, exp}, {7'h00, irq_out_n});
      if (irq_out_n !== exp)
         report_and_stop();
   endtask

   initial
   begin
      clk = 1'b0;
      rst = 1'b1;
      pin_value = 16'h0000;
      irq_enable_mask = 16'h0000;
      fail_count = 0;
      checks_done = 0;
      pair_tbl[0] = 8'hE4;
      pair_tbl[1] = 8'h39;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      for (int a = 8'h18; a <= 8'h1C; a++)
      begin
         rchk("reset value", a[6:0], 8'h00);
      end
      rchk("unmapped", 7'h7F, 8'h00);
      wait_line(1'b1);
      irq_enable_mask <= 16'h1001;
      wr(`IOEV_OFS_SENSE_LOW_A, 8'h09);
      pins(16'h0006);
      rchk("event a none", `IOEV_OFS_EVT_A, 8'h00);
      pins(16'h0001);
      rchk("event a", `IOEV_OFS_EVT_A, 8'h03);
      rchk("source a", `IOEV_OFS_IRQ_A, 8'h01);
      wait_line(1'b0);
      wr(`IOEV_OFS_IRQ_A, 8'h00);
      rchk("source a zero", `IOEV_OFS_IRQ_A, 8'h01);
      wr(`IOEV_OFS_IRQ_A, 8'h01);
      rchk("event a cleared", `IOEV_OFS_EVT_A, 8'h02);
      rchk("source a cleared", `IOEV_OFS_IRQ_A, 8'h00);
      wait_line(1'b1);
      wr(`IOEV_OFS_SENSE_LOW_A, 8'h0D);
      rchk("event a resense", `IOEV_OFS_EVT_A, 8'h00);
      rchk("sense low a", `IOEV_OFS_SENSE_LOW_A, 8'h0D);
      wr(`IOEV_OFS_SENSE_HIGH_B, 8'h03);
      pins(16'h0000);
      pins(16'h1001);
      rchk("event b", `IOEV_OFS_EVT_B, 8'h10);
      rchk("source b", `IOEV_OFS_IRQ_B, 8'h10);
      wr(`IOEV_OFS_EVT_B, 8'h10);
      rchk("source b cleared", `IOEV_OFS_IRQ_B, 8'h00);
      rchk("event b cleared", `IOEV_OFS_EVT_B, 8'h00);
      wait_line(1'b0);
      wr(`IOEV_OFS_IRQ_A, 8'h01);
      wait_line(1'b1);
      foreach (pair_tbl[t])
      begin
         wr(`IOEV_OFS_PAIR_UPPER, pair_tbl[t]);
         rchk("pair readback", `IOEV_OFS_PAIR_UPPER, pair_tbl[t]);
         for (int k = 0; k < 4; k++)
         begin
            exp_a2b[k] = pair_tbl[t][2*k +: 2] == `IOEV_LS_A2B;
            exp_b2a[k] = pair_tbl[t][2*k +: 2] == `IOEV_LS_B2A;
         end
         check("a to b", {4'h0, exp_a2b}, {4'h0, ls_a_to_b});
         check("b to a", {4'h0, exp_b2a}, {4'h0, ls_b_to_a});
      end
      report_and_stop();
   end

   initial
   begin
      repeat (100000) @(posedge clk);
      fail_count++;
      report_and_stop();
   end
endmodule
